// ==== evpd_cpu_mdl.sv ====
// Behavioural CPU side: mask flags, debug state and vector strobe
`timescale 1ns/1ps
`default_nettype none
module evpd_cpu_mdl
    import evpd_pkg::*;
(
    input  wire logic fire,      // One-cycle vector request from the bench
    input  wire logic i_mask,    // Interrupt mask flag
    input  wire logic x_mask,    // High-priority mask flag
    input  wire logic background_debug,       // Background debug running
    output evpd_cpu_t cpu        // Flags and strobe towards the unit
);
    // ----------------------------------------------------------------
    // Strobe and flags
    // ----------------------------------------------------------------
    // Pure wiring: the CPU owns the flags, the unit only reads them
    assign cpu = '{vec_req: fire, i_mask: i_mask, x_mask: x_mask, bdm_active: background_debug};
endmodule
`default_nettype wire

// ==== evpd_defs.svh ====
// Constants of the exception vector priority decoder
`ifndef EVPD_DEFS_SVH
`define EVPD_DEFS_SVH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define EVPD_OFF_VBASE  4'h0
`define EVPD_OFF_LAST   4'h4
`define EVPD_OFF_LIVE   4'h8

// ----------------------------------------------------------------
// Reset values, vector encodings and masked table sizes
// ----------------------------------------------------------------
`define EVPD_VBASE_RST  8'hff
`define EVPD_BDM_BASE   8'hff
`define EVPD_LO_SPUR    8'h80
`define EVPD_LO_FIRST   8'h82
`define EVPD_LO_XIRQ    8'hf4
`define EVPD_LO_SWI     8'hf6
`define EVPD_LO_TRAP    8'hf8
`define EVPD_VEC_POR    16'hfffe
`define EVPD_VEC_CLKMON 16'hfffc
`define EVPD_VEC_WDOG   16'hfffa
`define EVPD_NMASK      57
`define EVPD_IDXW       6

`endif

// ==== evpd_pkg.sv ====
// Types shared by the exception vector priority decoder
package evpd_pkg;

    // Non-masked-class requests travelling together
    typedef struct packed {
        logic rst_por;     // Pin, power-on or illegal-address reset
        logic rst_clkmon;  // Clock monitor reset
        logic rst_wdog;    // Watchdog timeout reset
        logic trap;        // Unimplemented opcode trap
        logic software_trap_request;         // Software trap or debug vector request
        logic xirq;        // Die-link error, high-priority maskable
    } evpd_nm_req_t;

    // CPU side flags and strobe
    typedef struct packed {
        logic vec_req;     // One-cycle vector request
        logic i_mask;      // Interrupt mask flag
        logic x_mask;      // High-priority mask flag
        logic bdm_active;  // Background debug running
    } evpd_cpu_t;

    // Whole state of the top module
    typedef struct packed {
        logic [7:0]  vbase;
        logic [15:0] vec_addr;
        logic        vec_ack;
        logic [15:0] last_vec;
        logic        waitreq;
        logic [31:0] rdata;
    } evpd_state_t;

endpackage

// ==== evpd_prio.sv ====
// Fixed priority finder over the masked-class requests
`timescale 1ns/1ps
`default_nettype none
`include "evpd_defs.svh"
module evpd_prio
    import evpd_pkg::*;
(
    input  wire logic [`EVPD_NMASK-1:0] req,
    input  wire logic [`EVPD_NMASK-1:0] en,
    output logic                         hit,
    output logic [`EVPD_IDXW-1:0]        idx
);

    // ----------------------------------------------------------------
    // Scan upward so the highest index, the highest vector, wins
    // ----------------------------------------------------------------
    always_comb begin
        hit = 1'b0;
        idx = '0;
        for (int i = 0; i < `EVPD_NMASK; i++) begin
            if (req[i] && en[i]) begin  // Needs its peripheral enable
                hit = 1'b1;
                idx = `EVPD_IDXW'(i);   // Later, higher entry overrides
            end
        end
    end

endmodule
`default_nettype wire

// ==== evpd_top.sv ====
// Exception vector priority decoder with Avalon-MM register slave
//
// The Avalon-MM register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "evpd_defs.svh"
module evpd_top
    import evpd_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    rst,
    // Avalon-MM slave
    input  wire logic [3:0]              avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [31:0]             avs_writedata,
    output logic [31:0]                  avs_readdata,
    output logic                         avs_waitrequest,
    // Requests
    input  wire evpd_nm_req_t            nm_req,
    input  wire logic [`EVPD_NMASK-1:0]  irq_req,
    input  wire logic [`EVPD_NMASK-1:0]  irq_en,
    // CPU
    input  wire evpd_cpu_t               cpu,
    output logic [15:0]                  vec_addr,
    output logic                         vec_ack,
    output logic                         wake
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    evpd_state_t st_q;   // All registers
    evpd_state_t st_d;   // Next value

    logic                   m_hit;     // Some enabled masked request
    logic [`EVPD_IDXW-1:0]  m_idx;     // Its index
    logic [7:0]             base;      // Upper vector byte in use
    logic                   xirq_eff;  // High-priority request unmasked
    logic                   nm_pend;   // Trap, software or high-priority
    logic                   m_fwd;     // Masked request forwarded
    logic [7:0]             m_lo;      // Low byte of masked vector
    logic [15:0]            winner;    // Live resolved vector
    logic                   acc;       // Bus access in progress
    logic                   wake_run;  // Wake term from live requests

    // ----------------------------------------------------------------
    // Masked-class priority finder
    // ----------------------------------------------------------------
    evpd_prio u_prio (
        .req (irq_req),
        .en  (irq_en),
        .hit (m_hit),
        .idx (m_idx)
    );

    // ----------------------------------------------------------------
    // Live vector resolution
    // ----------------------------------------------------------------
    always_comb begin
        // Debug firmware must find its handlers at a fixed page
        base     = cpu.bdm_active ? `EVPD_BDM_BASE : st_q.vbase;
        xirq_eff = nm_req.xirq && !cpu.x_mask;
        nm_pend  = nm_req.trap || nm_req.software_trap_request || xirq_eff;
        // Masked needs clear mask and nothing stronger pending
        m_fwd    = m_hit && !cpu.i_mask && !nm_pend;
        m_lo     = 8'(`EVPD_LO_FIRST + {1'b0, m_idx, 1'b0});
        // Highest vector address wins
        if (nm_req.rst_por) begin
            winner = `EVPD_VEC_POR;
        end else if (nm_req.rst_clkmon) begin
            winner = `EVPD_VEC_CLKMON;
        end else if (nm_req.rst_wdog) begin
            winner = `EVPD_VEC_WDOG;
        end else if (nm_req.trap) begin
            winner = {base, `EVPD_LO_TRAP};
        end else if (nm_req.software_trap_request) begin
            winner = {base, `EVPD_LO_SWI};
        end else if (xirq_eff) begin
            winner = {base, `EVPD_LO_XIRQ};
        end else if (m_fwd) begin
            winner = {base, m_lo};
        end else begin
            // Request vanished after recognition
            winner = {base, `EVPD_LO_SPUR};
        end
    end

    // ----------------------------------------------------------------
    // Wake-up: pure logic, so it works with the clock gated off
    // ----------------------------------------------------------------
    // Limitation: only requests that stay asserted without a clock help in stop
    always_comb begin
        wake_run = nm_pend || (m_hit && !cpu.i_mask);
    end
    assign wake = wake_run;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_d         = st_q;
        st_d.vec_ack = 1'b0;
        acc          = avs_read || avs_write;
        // Vector taken at the request edge, never earlier
        if (cpu.vec_req) begin
            st_d.vec_addr = winner;
            st_d.vec_ack  = 1'b1;
            st_d.last_vec = winner;
        end
        // Bus: one wait cycle, then answer for one cycle
        if (acc && st_q.waitreq) begin
            st_d.waitreq = 1'b0;
            if (avs_address == `EVPD_OFF_VBASE) begin
                st_d.rdata = {24'h0, st_q.vbase};
            end else if (avs_address == `EVPD_OFF_LAST) begin
                st_d.rdata = {16'h0, st_q.last_vec};
            end else if (avs_address == `EVPD_OFF_LIVE) begin
                st_d.rdata = {15'h0, wake_run, winner};
            end else begin
                // Unmapped offsets read as zero
                st_d.rdata = 32'h0;
            end
        end else begin
            st_d.waitreq = 1'b1;
            if (avs_write && !st_q.waitreq && avs_address == `EVPD_OFF_VBASE) begin
                st_d.vbase = avs_writedata[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers; reset restores the base before any vector fetch
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q.vbase    <= `EVPD_VBASE_RST;
            st_q.vec_addr <= 16'h0;
            st_q.vec_ack  <= 1'b0;
            st_q.last_vec <= 16'h0;
            st_q.waitreq  <= 1'b1;
            st_q.rdata    <= 32'h0;
        end else begin
            st_q <= st_d;
        end
    end

    assign vec_addr        = st_q.vec_addr;
    assign vec_ack         = st_q.vec_ack;
    assign avs_waitrequest = st_q.waitreq;
    assign avs_readdata    = st_q.rdata;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic no_rst;  // No reset cause pending
    assign no_rst = !(nm_req.rst_por || nm_req.rst_clkmon || nm_req.rst_wdog);

    AST_BASE_AFTER_RESET: assert property (
        $fell(rst) |-> st_q.vbase == `EVPD_VBASE_RST)
        else $error("Base not restored by reset");
    AST_POR_VECTOR: assert property (
        cpu.vec_req && nm_req.rst_por |=> vec_addr == `EVPD_VEC_POR && vec_ack)
        else $error("Power-on vector wrong");
    AST_CLKMON_VECTOR: assert property (
        cpu.vec_req && !nm_req.rst_por && nm_req.rst_clkmon
        |=> vec_addr == `EVPD_VEC_CLKMON)
        else $error("Clock monitor vector wrong");
    AST_TRAP_VECTOR: assert property (
        cpu.vec_req && no_rst && nm_req.trap && !cpu.bdm_active
        |=> vec_addr == {$past(st_q.vbase), `EVPD_LO_TRAP})
        else $error("Trap vector wrong");
    AST_DEBUG_PAGE: assert property (
        cpu.vec_req && no_rst && cpu.bdm_active |=> vec_addr[15:8] == `EVPD_BDM_BASE)
        else $error("Debug page not forced");
    AST_NM_BEATS_MASKED: assert property (
        cpu.vec_req && no_rst && nm_pend |=> vec_addr[7:0] >= `EVPD_LO_XIRQ)
        else $error("Masked request beat a stronger one");
    AST_SPURIOUS: assert property (
        cpu.vec_req && no_rst && !nm_pend && (!m_hit || cpu.i_mask)
        |=> vec_addr[7:0] == `EVPD_LO_SPUR)
        else $error("Spurious vector missing");
    AST_ACK_PULSE: assert property (
        cpu.vec_req ##1 !cpu.vec_req |-> vec_ack ##1 !vec_ack)
        else $error("Vector answer not a single pulse");
    AST_MASK_BLOCKS_WAKE: assert property (
        cpu.i_mask && !nm_pend |-> !wake)
        else $error("Masked request woke the CPU");
    AST_BUS_ANSWER: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("Bus answer late");

endmodule
`default_nettype wire

// ==== exception_vector_priority_decoder_tb.sv ====
// Self-checking bench comparing the unit against a priority model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module exception_vector_priority_decoder_tb;
    import evpd_pkg::*;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic        clk = 0, rst = 1;          // Clock and reset
    logic [3:0]  avs_address = 4'h0;        // Bus address
    logic        avs_read = 0, avs_write = 0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic        avs_waitrequest, vec_ack, wake;
    logic [15:0] vec_addr;
    evpd_nm_req_t nm_req = '0;              // Non-masked-class requests
    logic [56:0] irq_req = '0, irq_en = '0; // Masked-class requests
    logic        fire = 0, im = 1, xm = 1, bd = 0;
    evpd_cpu_t   cpu;
    logic [7:0]  base;                      // Model copy of the base
    int          error_cnt = 0, check_count = 0, cyc = 0, seed = 16;

    always #4 clk = ~clk;                   // 125 MHz

    evpd_cpu_mdl cpu_m (.fire(fire), .i_mask(im), .x_mask(xm), .background_debug(bd), .cpu(cpu));
    evpd_top uut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .nm_req(nm_req), .irq_req(irq_req),
        .irq_en(irq_en), .cpu(cpu), .vec_addr(vec_addr), .vec_ack(vec_ack), .wake(wake));

    // ----------------------------------------------------------------
    // Reference model
    // ----------------------------------------------------------------
    // Winner by descending vector address, masked class last
    function automatic logic [15:0] mdl(input logic [5:0] nm, input logic [56:0] rq, en);
        logic [7:0] hi;
        hi = bd ? 8'hff : base;
        if (nm[5]) return 16'hfffe;
        if (nm[4]) return 16'hfffc;
        if (nm[3]) return 16'hfffa;
        if (nm[2]) return {hi, 8'hf8};
        if (nm[1]) return {hi, 8'hf6};
        if (nm[0] && !xm) return {hi, 8'hf4};
        if (!im) for (int i = 56; i >= 0; i--) if (rq[i] && en[i]) return {hi, 8'h82 + 8'(2 * i)};
        return {hi, 8'h80};
    endfunction

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    // One bus access; waits for waitrequest low under a bound
    // Only the hang guard ends a wait that never sees waitrequest low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        if (wr) avs_write <= 1; else avs_read <= 1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 0;
        avs_write <= 0;
        @(posedge clk);
    endtask

    // Requests are held through the taking edge until the answer
    task automatic vec(input logic [5:0] nm, input logic [56:0] rq, en);
        logic [15:0] e;
        nm_req <= nm;
        irq_req <= rq;
        irq_en <= en;
        fire <= 1;
        @(posedge clk);
        e = mdl(nm, rq, en);
        fire <= 0;
        #1;
        `CHK(vec_ack, 1'b1)
        `CHK(vec_addr, e)
        `CHK(wake, nm[2] | nm[1] | (nm[0] & !xm) | ((|(rq & en)) & !im))
        @(posedge clk);
        #1;
        `CHK(vec_ack, 1'b0)
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        base = 8'hff;
        repeat (4) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        bus(0, 4'h0, 0);
        `CHK(rd, 32'h0000_00ff)
        bus(0, 4'hc, 0);
        `CHK(rd, 32'h0)
        bus(1, 4'h0, 32'h0000_003c);
        base = 8'h3c;
        bus(0, 4'h0, 0);
        `CHK(rd, 32'h0000_003c)
        im <= 0;
        xm <= 0;
        vec(6'h0, '0, '1);
        // Each non-masked code alone, over full masked traffic
        for (int k = 0; k < 6; k++) vec(6'(1 << k), '1, '1);
        for (int k = 0; k < 57; k += 8) vec(6'h0, 57'(1) << k, '1);
        // Random traffic, masks and debug state
        repeat (300) begin
            im <= $random(seed);
            xm <= $random(seed);
            bd <= ($random(seed) & 7) == 0;
            @(posedge clk);
            vec(($random(seed) & 15) == 0 ? 6'($random(seed)) : 6'($random(seed) & 7),
                {$random(seed), $random(seed)} & {$random(seed), $random(seed)},
                {$random(seed), $random(seed)});
        end
        bd <= 0;
        // Reset in mid-run restores the base
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        base = 8'hff;
        @(posedge clk);
        bus(0, 4'h0, 0);
        `CHK(rd, 32'h0000_00ff)
        vec(6'h20, '1, '1);
        bus(1, 4'h4, 32'h0000_1234);
        bus(0, 4'h4, 0);
        `CHK(rd, 32'h0000_fffe)
        close_out();
    end
endmodule
`undef CHK
`default_nettype wire
